// >>> hw/plr_params.svh
// timing counts, register offsets and field positions of the long-press reset block
`ifndef PLR_PARAMS_SVH
`define PLR_PARAMS_SVH

// timebase
`define PLR_CLK_HZ 20000000
`define PLR_CYC_PER_MS (`PLR_CLK_HZ / 1000)

// press_hold_delay is a whole number of 500 ms steps, 1 to 20 steps
`define PLR_HOLD_STEP_MS 500
`define PLR_HOLD_STEPS_DEF 1
`define PLR_HOLD_STEPS_MAX 20

// test_entry_delay, fixed_pulse_length, test hold divider
`define PLR_TEST_ENTRY_MS 42
`define PLR_PULSE_MS 210
`define PLR_TEST_DIV 128

// register offsets (byte addresses)
`define PLR_OFF_CTRL 12'h000
`define PLR_OFF_STATUS 12'h004
`define PLR_OFF_COUNT 12'h008

// control fields and reset value
`define PLR_CTRL_EN_BIT 0
`define PLR_CTRL_RST 32'h0000_0001

// status fields
`define PLR_ST_TEST_BIT 0
`define PLR_ST_RST_BIT 1
`define PLR_ST_PRESS_BIT 2
`define PLR_ST_SUPPLY_BIT 3
`define PLR_ST_LEVEL_BIT 4

// bus responses
`define PLR_RESP_OKAY 2'b00
`define PLR_RESP_SLVERR 2'b10

`endif

// >>> hw/plr_pkg.sv
// types shared by the long-press reset block
package plr_pkg;

  typedef logic [11:0] plr_addr_t;
  typedef logic [31:0] plr_word_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HOLD,
    ST_BTN,
    ST_PULSE,
    ST_RELEASE,
    ST_ENTRY,
    ST_LEVEL
  } plr_state_t;

endpackage

// >>> hw/plr_sync2.sv
// two-stage synchroniser for a group of level inputs
`timescale 1ns/1ps
`default_nettype none

module plr_sync2 #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic core_clk, // block clock
  input wire logic srst, // synchronous reset, active high
  input wire logic ce, // clock enable, freezes state when low
  input wire logic [W-1:0] d_in, // asynchronous levels
  output logic [W-1:0] q_out // synchronised levels
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta_q <= RST_VAL;
      q_out <= RST_VAL;
    end else if (ce) begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end

endmodule

`default_nettype wire

// >>> hw/plr_long_press_reset.sv
// long-press reset generator with test mode and register access
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "plr_params.svh"

module plr_long_press_reset
  import plr_pkg::*;
#(
  parameter int unsigned HOLD_STEPS = `PLR_HOLD_STEPS_DEF,
  parameter bit FIXED_PULSE = 1'b0,
  parameter bit RST_ACTIVE_HIGH = 1'b0,
  parameter bit OPEN_DRAIN = 1'b1,
  parameter int unsigned CNT_W = 28,
  parameter int unsigned HOLD_CYCLES = HOLD_STEPS * `PLR_HOLD_STEP_MS * `PLR_CYC_PER_MS,
  parameter int unsigned TEST_ENTRY_CYCLES = `PLR_TEST_ENTRY_MS * `PLR_CYC_PER_MS,
  parameter int unsigned PULSE_CYCLES = `PLR_PULSE_MS * `PLR_CYC_PER_MS
) (
  input wire logic core_clk, // block clock, 20 MHz
  input wire logic srst, // synchronous reset, acts as power-on restart
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic button_in_n, // push-button, low = pressed
  input wire logic test_entry_level, // overvoltage flag on the button pin
  input wire logic supply_ok, // supply within operating range
  output logic rst_out, // reset pin output level
  output logic rst_oe, // reset pin output enable
  input wire plr_addr_t s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire plr_word_t s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire plr_addr_t s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output plr_word_t s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);

  localparam int unsigned TEST_HOLD_CYCLES = HOLD_CYCLES / `PLR_TEST_DIV;
  // a literal cannot be bit-selected, so the control reset word gets a name
  localparam plr_word_t CTRL_RST_VAL = `PLR_CTRL_RST;
  localparam longint unsigned CNT_LIM = longint'(1) << CNT_W;

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks

  if (HOLD_STEPS < 1 || HOLD_STEPS > `PLR_HOLD_STEPS_MAX) begin : g_bad_steps
    $error("hold steps out of range");
  end
  if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
    $error("counter width out of range");
  end
  if (TEST_HOLD_CYCLES < 1 || TEST_ENTRY_CYCLES < 1 || PULSE_CYCLES < 1) begin : g_bad_cnt
    $error("delay counts must be at least one cycle");
  end
  if (HOLD_CYCLES >= CNT_LIM || TEST_ENTRY_CYCLES >= CNT_LIM || PULSE_CYCLES >= CNT_LIM)
  begin : g_bad_fit
    $error("delay count does not fit the counter");
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // counter reached the last cycle of a delay
  function automatic logic cnt_hit(input logic [CNT_W-1:0] c, input int unsigned lim);
    return c >= CNT_W'(lim - 1);
  endfunction

  // word-aligned offset match, low address bits ignored
  function automatic logic addr_is(input plr_addr_t a, input plr_addr_t off);
    return a[11:2] == off[11:2];
  endfunction

  function automatic logic addr_known(input plr_addr_t a);
    return addr_is(a, `PLR_OFF_CTRL) || addr_is(a, `PLR_OFF_STATUS) ||
      addr_is(a, `PLR_OFF_COUNT);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisation

  logic [2:0] sync_w;
  logic press;
  logic level;
  logic sup_ok;

  // idle values at reset: button released, no overvoltage, supply low
  plr_sync2 #(
    .W(3),
    .RST_VAL(3'b001)
  ) u_sync (
    .core_clk(core_clk),
    .srst(srst),
    .ce(ce),
    .d_in({supply_ok, test_entry_level, button_in_n}),
    .q_out(sync_w)
  );

  assign press = ~sync_w[0];
  assign level = sync_w[1];
  assign sup_ok = sync_w[2];

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  plr_state_t state_q;
  plr_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic cnt_clr;
  logic test_mode_q;
  logic en_q;
  logic asserted;
  int unsigned hold_lim;

  assign hold_lim = test_mode_q ? TEST_HOLD_CYCLES : HOLD_CYCLES;
  assign asserted = (state_q == ST_BTN) || (state_q == ST_PULSE) || (state_q == ST_LEVEL);

  // next state; software disable parks the block in idle
  always_comb begin
    state_d = state_q;
    cnt_clr = 1'b0;
    if (!en_q) begin
      state_d = ST_IDLE;
      cnt_clr = 1'b1;
    end else if (level && !test_mode_q) begin
      state_d = ST_ENTRY;
      cnt_clr = 1'b1;
    end else begin
      case (state_q)
        ST_IDLE: begin
          // no press starts being timed while the supply is low
          if (sup_ok && press) begin
            state_d = ST_HOLD;
            cnt_clr = 1'b1;
          end
        end
        ST_HOLD: begin
          if (!press) begin
            state_d = ST_IDLE;
            cnt_clr = 1'b1;
          end else if (cnt_hit(cnt_q, hold_lim)) begin
            state_d = FIXED_PULSE ? ST_PULSE : ST_BTN;
            cnt_clr = 1'b1;
          end
        end
        ST_BTN: begin
          if (!press) begin
            state_d = ST_IDLE;
          end
        end
        ST_PULSE: begin
          // button level is ignored until the pulse ends
          if (cnt_hit(cnt_q, PULSE_CYCLES)) begin
            state_d = ST_RELEASE;
            cnt_clr = 1'b1;
          end
        end
        ST_RELEASE: begin
          // a button still held must not start a second hold
          if (!press) begin
            state_d = ST_IDLE;
          end
        end
        ST_ENTRY: begin
          if (cnt_hit(cnt_q, TEST_ENTRY_CYCLES)) begin
            state_d = FIXED_PULSE ? ST_PULSE : ST_LEVEL;
            cnt_clr = 1'b1;
          end
        end
        ST_LEVEL: begin
          if (!level) begin
            state_d = ST_IDLE;
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  // state register; reset lands in normal idle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // shared delay counter
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (cnt_clr) begin
        cnt_q <= '0;
      end else if (state_q == ST_HOLD || state_q == ST_PULSE || state_q == ST_ENTRY) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // test mode only leaves through reset
  always_ff @(posedge core_clk) begin
    if (srst) begin
      test_mode_q <= 1'b0;
    end else if (ce && en_q && level) begin
      test_mode_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset pin drive

  // open drain only pulls low; push-pull drives unless idle on low supply
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rst_out <= ~RST_ACTIVE_HIGH;
      rst_oe <= 1'b0;
    end else if (ce) begin
      rst_out <= RST_ACTIVE_HIGH ? asserted : ~asserted;
      rst_oe <= (asserted || sup_ok) &&
        (!OPEN_DRAIN || (RST_ACTIVE_HIGH ? !asserted : asserted));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus write side

  plr_addr_t awaddr_q;
  plr_word_t wdata_q;
  logic [3:0] wstrb_q;
  logic aw_have_q;
  logic w_have_q;
  logic wr_do;

  // address and data are taken in either order, one write at a time
  assign wr_do = aw_have_q && w_have_q && !s_axi_bvalid;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_awready <= 1'b0;
      aw_have_q <= 1'b0;
      awaddr_q <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (wr_do) begin
        aw_have_q <= 1'b0;
      end else if (!aw_have_q && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_wready <= 1'b0;
      w_have_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (wr_do) begin
        w_have_q <= 1'b0;
      end else if (!w_have_q && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // response follows both halves; unmapped offsets answer slave error
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PLR_RESP_OKAY;
    end else if (ce) begin
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_known(awaddr_q) ? `PLR_RESP_OKAY : `PLR_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control register, only byte lane 0 holds a field
  always_ff @(posedge core_clk) begin
    if (srst) begin
      en_q <= CTRL_RST_VAL[`PLR_CTRL_EN_BIT];
    end else if (ce && wr_do && addr_is(awaddr_q, `PLR_OFF_CTRL) && wstrb_q[0]) begin
      en_q <= wdata_q[`PLR_CTRL_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus read side

  // status is a live snapshot taken at the address handshake
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `PLR_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= addr_known(s_axi_araddr) ? `PLR_RESP_OKAY : `PLR_RESP_SLVERR;
        s_axi_rdata <= '0;
        if (addr_is(s_axi_araddr, `PLR_OFF_CTRL)) begin
          s_axi_rdata[`PLR_CTRL_EN_BIT] <= en_q;
        end else if (addr_is(s_axi_araddr, `PLR_OFF_STATUS)) begin
          s_axi_rdata[`PLR_ST_TEST_BIT] <= test_mode_q;
          s_axi_rdata[`PLR_ST_RST_BIT] <= asserted;
          s_axi_rdata[`PLR_ST_PRESS_BIT] <= press;
          s_axi_rdata[`PLR_ST_SUPPLY_BIT] <= sup_ok;
          s_axi_rdata[`PLR_ST_LEVEL_BIT] <= level;
        end else if (addr_is(s_axi_araddr, `PLR_OFF_COUNT)) begin
          s_axi_rdata <= 32'(cnt_q);
        end
      end else if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
      end else begin
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// >>> test/plr_long_press_reset_sva.sv
// assertion checker watching the pins of the long-press reset generator
`timescale 1ns/1ps
`default_nettype none
module plr_long_press_reset_sva #(
  parameter int unsigned HOLD_CYCLES = 256,
  parameter int unsigned TEST_ENTRY_CYCLES = 40,
  parameter bit FIXED_PULSE = 1'b0,
  parameter bit RST_ACTIVE_HIGH = 1'b0,
  parameter bit OPEN_DRAIN = 1'b1
) (
  input wire logic core_clk, // block clock
  input wire logic srst, // sync reset
  input wire logic button_in_n, // raw button
  input wire logic test_entry_level, // raw test flag
  input wire logic supply_ok, // raw supply flag
  input wire logic rst_out, // pin level
  input wire logic rst_oe, // pin enable
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic s_axi_rvalid // r valid
);
  // two sync flops, the step into hold or entry and the output flop add 4 cycles, inside each bound
  localparam int HOLD_LO = HOLD_CYCLES + 2;
  localparam int HOLD_HI = HOLD_CYCLES + 5;
  localparam int ENT_LO = TEST_ENTRY_CYCLES + 2;
  localparam int ENT_HI = TEST_ENTRY_CYCLES + 6;
  logic [31:0] press_cnt_q;
  logic test_seen_q;
  logic asserted;
  assign asserted = rst_oe && (rst_out == RST_ACTIVE_HIGH);
  ////////////////////////////////////////////////
  // run length of the raw press, saturating
  always_ff @(posedge core_clk) begin
    if (srst || button_in_n) press_cnt_q <= '0;
    else if (press_cnt_q != 32'hffff_ffff) press_cnt_q <= press_cnt_q + 32'h0000_0001;
  end
  // test flag ever seen since reset
  always_ff @(posedge core_clk) begin
    if (srst) test_seen_q <= 1'b0;
    else if (test_entry_level) test_seen_q <= 1'b1;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////
  a_reset_idle: assert property (disable iff (1'b0)
    srst |=> !rst_oe && rst_out == !RST_ACTIVE_HIGH) else $error("pin not idle after reset");
  a_hold_window: assert property ($rose(asserted) && !test_seen_q |->
    press_cnt_q >= HOLD_LO && press_cnt_q <= HOLD_HI) else $error("reset without full hold");
  a_release_ends: assert property (!FIXED_PULSE && !test_seen_q && asserted &&
    button_in_n |-> ##[0:5] !asserted) else $error("reset outlived release");
  a_test_entry: assert property ($rose(test_entry_level) && !test_seen_q |->
    ##[ENT_LO:ENT_HI] asserted) else $error("no reset after entry delay");
  a_test_hold: assert property (test_seen_q ##0 (!button_in_n &&
    !test_entry_level && supply_ok)[*8] |-> asserted) else $error("short hold not used");
  a_supply_hiz: assert property ((!supply_ok && button_in_n &&
    !test_entry_level)[*5] |-> !rst_oe) else $error("pin driven on low supply");
  a_drain_drive: assert property (rst_oe |-> (!OPEN_DRAIN || rst_out == 1'b0))
    else $error("open drain drove high");
  a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> !s_axi_awready ##1 s_axi_bvalid) else $error("write answer late");
  a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  c_long_press: cover property ($rose(asserted) && !test_seen_q);
  c_test_press: cover property ($rose(asserted) && test_seen_q && !test_entry_level);
  c_read: cover property (s_axi_arvalid && s_axi_arready);
endmodule
`default_nettype wire

// >>> test/plr_button_host.sv
// push-button and host reset-input model on the far side of the pin pair
`timescale 1ns/1ps
`default_nettype none
module plr_button_host #(
  parameter bit RST_ACTIVE_HIGH = 1'b0
) (
  input wire logic press, // bench holds the button down
  output logic button_in_n, // contact to ground, pulled up
  input wire logic rst_out, // pin level from the block
  input wire logic rst_oe, // pin driven by the block
  output logic pin_level, // resolved reset wire
  output logic host_in_reset // host sees reset
);
  // closed contact pulls low; open contact reads high at once, whatever the supply
  assign button_in_n = !press;
  // released wire floats to the pull-up, not the last driven level
  assign pin_level = rst_oe ? rst_out : 1'b1;
  assign host_in_reset = (pin_level == RST_ACTIVE_HIGH);
endmodule
`default_nettype wire

// >>> test/plr_long_press_reset_bench.sv
// self-checking bench for the long-press reset generator
`timescale 1ns/1ps
`default_nettype none
`include "plr_params.svh"
module plr_long_press_reset_bench;
  import plr_pkg::*;
  localparam int H = 256;
  localparam int TE = 40;
  logic core_clk = 1'b0, srst = 1'b1, ce = 1'b1, test_entry_level = 1'b0;
  logic supply_ok = 1'b1, press = 1'b0;
  logic button_in_n, rst_out, rst_oe, pin_level, host_in_reset;
  plr_addr_t s_axi_awaddr = '0, s_axi_araddr = '0;
  plr_word_t s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] rnd = 32'h0000_0059;
  int failures = 0;
  int n_compared = 0;
  int thr = H;
  plr_long_press_reset #(.HOLD_CYCLES(H), .TEST_ENTRY_CYCLES(TE), .PULSE_CYCLES(30)) u_dut (
    .core_clk, .srst, .ce, .button_in_n, .test_entry_level, .supply_ok, .rst_out, .rst_oe,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  plr_button_host u_host (.press, .button_in_n, .rst_out, .rst_oe, .pin_level,
    .host_in_reset);
  ////////////////////////////////////////////////
  // 20 MHz clock
  initial forever #25 core_clk = !core_clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input string name, input logic [33:0] seen, input logic [33:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // each channel released on its own ready; bready held until the answer
  task automatic axi_wr(input plr_addr_t a, input plr_word_t d, input logic [1:0] er);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check("bresp", s_axi_bresp, er);
  endtask
  task automatic axi_rd(input plr_addr_t a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // model: reset shows only for presses well past the hold threshold
  task automatic hold(input int len);
    if (len + 8 > thr && len < thr + 8) len = thr + 8;
    // a zero-length press would set and clear the button in one time step
    if (len < 1) len = 1;
    press <= 1'b1;
    repeat (len) @(posedge core_clk);
    check("rst held", host_in_reset, len >= thr + 8);
    press <= 1'b0;
    repeat (6) @(posedge core_clk);
    check("rst released", host_in_reset, 1'b0);
  endtask
  task automatic results();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////
  // watchdog well beyond the few thousand cycles the run needs
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    results();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    repeat (2) @(posedge core_clk);
    axi_rd(`PLR_OFF_CTRL);
    check("ctrl", {rd, rs}, {`PLR_CTRL_RST, `PLR_RESP_OKAY});
    axi_rd(`PLR_OFF_STATUS);
    check("status", {rd, rs}, {32'h0000_0008, `PLR_RESP_OKAY});
    axi_rd(12'h00c);
    check("unmapped", {rd, rs}, {32'h0000_0000, `PLR_RESP_SLVERR});
    repeat (3) begin
      rnd = xs(rnd);
      hold(int'(rnd % H));
    end
    hold(H - 40);
    hold(H - 40);
    // hold counter read mid-press: sync 2 edges, idle to hold 1 edge, then counts up
    press <= 1'b1;
    repeat (20) @(posedge core_clk);
    axi_rd(`PLR_OFF_COUNT);
    check("count", {rd, rs}, {32'h0000_0012, `PLR_RESP_OKAY});
    press <= 1'b0;
    repeat (6) @(posedge core_clk);
    hold(H + 8);
    supply_ok <= 1'b0;
    repeat (6) @(posedge core_clk);
    check("oe", rst_oe, 1'b0);
    thr = 1000;
    hold(H + 20);
    supply_ok <= 1'b1;
    rnd = xs(rnd);
    axi_wr(`PLR_OFF_CTRL, {rnd[31:1], 1'b0}, `PLR_RESP_OKAY);
    hold(H + 20);
    axi_wr(`PLR_OFF_CTRL, 32'h0000_0001, `PLR_RESP_OKAY);
    axi_wr(12'h010, rnd, `PLR_RESP_SLVERR);
    thr = H;
    test_entry_level <= 1'b1;
    repeat (TE + 10) @(posedge core_clk);
    check("rst test", host_in_reset, 1'b1);
    test_entry_level <= 1'b0;
    repeat (6) @(posedge core_clk);
    check("rst test", host_in_reset, 1'b0);
    axi_rd(`PLR_OFF_STATUS);
    check("status", {rd, rs}, {32'h0000_0009, `PLR_RESP_OKAY});
    thr = H / 128;
    repeat (3) begin
      rnd = xs(rnd);
      hold(int'(rnd % 64));
    end
    srst <= 1'b1;
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    repeat (2) @(posedge core_clk);
    axi_rd(`PLR_OFF_STATUS);
    check("status", {rd, rs}, {32'h0000_0008, `PLR_RESP_OKAY});
    thr = H;
    hold(H - 20);
    // clock enable low freezes the timer, so even a long press goes unseen
    ce <= 1'b0;
    thr = 1000;
    hold(H + 20);
    ce <= 1'b1;
    repeat (2) @(posedge core_clk);
    results();
  end
endmodule
bind plr_long_press_reset plr_long_press_reset_sva #(.HOLD_CYCLES(HOLD_CYCLES),
  .TEST_ENTRY_CYCLES(TEST_ENTRY_CYCLES), .FIXED_PULSE(FIXED_PULSE),
  .RST_ACTIVE_HIGH(RST_ACTIVE_HIGH), .OPEN_DRAIN(OPEN_DRAIN)) u_sva (.core_clk, .srst,
  .button_in_n, .test_entry_level, .supply_ok, .rst_out, .rst_oe, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid);
`default_nettype wire
